// >>> core/sore_exec_regs.vh
// Constants for the store/option/return execute block.
// Assumes a 14-bit instruction word and 13-bit program counter.
`ifndef SORE_EXEC_REGS_VH
`define SORE_EXEC_REGS_VH
`define SORE_INSTR_W 14
`define SORE_PC_W 13
`define SORE_FADDR_W 7
// Accumulator store: 00 0000 1fff ffff.
`define SORE_STORE_MASK 14'h3F80
`define SORE_STORE_CODE 14'h0080
// Legacy option load: 00 0000 0110 0010.
`define SORE_OPTLOAD_CODE 14'h0062
// No-operation: 00 0000 0xx0 0000.
`define SORE_NOP_MASK 14'h3F9F
`define SORE_NOP_CODE 14'h0000
// Interrupt return: 00 0000 0000 1001.
`define SORE_IRET_CODE 14'h0009
// File address of the option configuration register.
`define SORE_OPTION_ADDR 7'h01
// Global interrupt enable position in the interrupt control register.
`define SORE_IRQ_EN_BIT 7
`define SORE_OPTION_RST 8'hFF
`define SORE_IRET_CYCLES 2
`endif

// >>> core/sore_exec.v
// Execute stage for accumulator store, option load, no-operation and interrupt return.
// Assumes the fetch logic presents one instruction with i_instr_valid per cycle and
// honours o_flush by discarding the prefetched word.
//
// Overview of operation
// - Accumulator store copies accumulator into addressed register.
// - Option-load writes accumulator into option register.
// - Option register also reachable through ordinary store.
// - Interrupt return pops stack into program counter.
// - Interrupt return sets global interrupt enable bit.
// - Interrupt return takes two cycles, refilling pipeline.
`include "sore_exec_regs.vh"
module sore_exec (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_instr_valid,
    input wire [`SORE_INSTR_W-1:0] i_instr,
    input wire [7:0] i_accum,
    input wire [`SORE_PC_W-1:0] i_pc,
    input wire [`SORE_PC_W-1:0] i_stack_top_entry,
    input wire [7:0] i_interrupt_control_reg,
    output wire o_file_we,
    output wire [`SORE_FADDR_W-1:0] o_file_addr,
    output wire [7:0] o_file_wdata,
    output wire [7:0] o_option_reg,
    output wire o_stack_pop,
    output wire o_pc_load,
    output wire [`SORE_PC_W-1:0] o_pc_next,
    output wire o_irq_ctrl_we,
    output wire [7:0] o_irq_ctrl_wdata,
    output wire o_flush,
    output wire o_busy
);
    localparam ST_RUN = 1'h0;
    localparam ST_REFILL = 1'h1;
    // Cycles spent in refill after the return's own cycle.
    // A counter rather than a single state keeps the cycle count in one constant.
    localparam [31:0] REFILL_LOAD = `SORE_IRET_CYCLES - 1;

    // Sequencer: the cycle after an interrupt return is a bubble that decodes nothing.
    reg state_q;
    reg state_d;
    reg [1:0] refill_cnt_q;
    reg [1:0] refill_cnt_d;

    // File register write port.
    reg file_we_q;
    reg file_we_d;
    reg [`SORE_FADDR_W-1:0] file_addr_q;
    reg [`SORE_FADDR_W-1:0] file_addr_d;
    reg [7:0] file_wdata_q;
    reg [7:0] file_wdata_d;

    // Option configuration register, held here so both write paths meet in one place.
    reg [7:0] option_q;
    reg [7:0] option_d;

    // Stack, program counter and interrupt control requests.
    reg stack_pop_q;
    reg stack_pop_d;
    reg pc_load_q;
    reg pc_load_d;
    reg [`SORE_PC_W-1:0] pc_next_q;
    reg [`SORE_PC_W-1:0] pc_next_d;
    reg irq_ctrl_we_q;
    reg irq_ctrl_we_d;
    reg [7:0] irq_ctrl_wdata_q;
    reg [7:0] irq_ctrl_wdata_d;
    reg flush_q;
    reg flush_d;
    reg busy_q;
    reg busy_d;

    // Instruction decode.
    wire is_store;
    wire is_optload;
    wire is_nop;
    wire is_iret;
    wire accept;
    wire [`SORE_FADDR_W-1:0] faddr;
    wire hits_option;
    wire [`SORE_PC_W-1:0] pc_inc;
    wire [7:0] irq_ctrl_set;
    genvar gi;

    assign is_store = ((i_instr & `SORE_STORE_MASK) == `SORE_STORE_CODE);
    assign is_optload = (i_instr == `SORE_OPTLOAD_CODE);
    assign is_nop = ((i_instr & `SORE_NOP_MASK) == `SORE_NOP_CODE);
    assign is_iret = (i_instr == `SORE_IRET_CODE);
    assign accept = i_instr_valid && (state_q == ST_RUN);
    assign faddr = i_instr[`SORE_FADDR_W-1:0];
    assign hits_option = (faddr == `SORE_OPTION_ADDR);
    assign pc_inc = i_pc + {{(`SORE_PC_W-1){1'h0}}, 1'h1};

    // Read-modify-write image of the interrupt control register: only the enable bit is forced.
    // The other bits pass through, so a flag raised in the same cycle is not lost here.
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_irq_ctrl_bit
            if (gi == `SORE_IRQ_EN_BIT) begin : g_enable
                assign irq_ctrl_set[gi] = 1'h1;
            end else begin : g_keep
                assign irq_ctrl_set[gi] = i_interrupt_control_reg[gi];
            end
        end
    endgenerate

    // Next-state logic; pulses default low so each request lasts exactly one cycle.
    always @* begin
        state_d = state_q;
        refill_cnt_d = refill_cnt_q;
        file_we_d = 1'h0;
        file_addr_d = file_addr_q;
        file_wdata_d = file_wdata_q;
        option_d = option_q;
        stack_pop_d = 1'h0;
        pc_load_d = 1'h0;
        pc_next_d = pc_next_q;
        irq_ctrl_we_d = 1'h0;
        irq_ctrl_wdata_d = irq_ctrl_wdata_q;
        flush_d = 1'h0;
        busy_d = busy_q;
        case (state_q)
            ST_RUN: begin
                busy_d = 1'h0;
                if (accept) begin
                    // Every accepted word moves the program counter on unless it is replaced below.
                    pc_next_d = pc_inc;
                    if (is_store) begin
                        file_we_d = 1'h1;
                        file_addr_d = faddr;
                        file_wdata_d = i_accum;
                        if (hits_option) begin
                            // The file array is written too, so a later read there sees this value.
                            option_d = i_accum;
                        end
                    end else if (is_optload) begin
                        // Kept for old code; the ordinary store above reaches the same register.
                        option_d = i_accum;
                    end else if (is_iret) begin
                        stack_pop_d = 1'h1;
                        pc_load_d = 1'h1;
                        pc_next_d = i_stack_top_entry;
                        irq_ctrl_we_d = 1'h1;
                        irq_ctrl_wdata_d = irq_ctrl_set;
                        flush_d = 1'h1;
                        busy_d = 1'h1;
                        refill_cnt_d = REFILL_LOAD[1:0];
                        state_d = ST_REFILL;
                    end else if (is_nop) begin
                        // No register, flag, stack entry or memory is touched.
                        busy_d = 1'h0;
                    end
                end
            end
            ST_REFILL: begin
                // The prefetched word is discarded; the fetch side refills from o_pc_next.
                refill_cnt_d = refill_cnt_q - 2'h1;
                if (refill_cnt_q <= 2'h1) begin
                    busy_d = 1'h0;
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= ST_RUN;
            refill_cnt_q <= 2'h0;

            file_we_q <= 1'h0;
            file_addr_q <= {`SORE_FADDR_W{1'h0}};
            file_wdata_q <= 8'h00;
            option_q <= `SORE_OPTION_RST;

            stack_pop_q <= 1'h0;
            pc_load_q <= 1'h0;
            pc_next_q <= {`SORE_PC_W{1'h0}};
            irq_ctrl_we_q <= 1'h0;
            irq_ctrl_wdata_q <= 8'h00;
            flush_q <= 1'h0;
            busy_q <= 1'h0;
        end else begin
            state_q <= state_d;
            refill_cnt_q <= refill_cnt_d;

            file_we_q <= file_we_d;
            file_addr_q <= file_addr_d;
            file_wdata_q <= file_wdata_d;
            option_q <= option_d;

            stack_pop_q <= stack_pop_d;
            pc_load_q <= pc_load_d;
            pc_next_q <= pc_next_d;
            irq_ctrl_we_q <= irq_ctrl_we_d;
            irq_ctrl_wdata_q <= irq_ctrl_wdata_d;
            flush_q <= flush_d;
            busy_q <= busy_d;
        end
    end

    // Every output is a flip-flop, so the fetch side sees no decode glitches.
    assign o_file_we = file_we_q;
    assign o_file_addr = file_addr_q;
    assign o_file_wdata = file_wdata_q;
    assign o_option_reg = option_q;

    assign o_stack_pop = stack_pop_q;
    assign o_pc_load = pc_load_q;
    assign o_pc_next = pc_next_q;
    assign o_irq_ctrl_we = irq_ctrl_we_q;
    assign o_irq_ctrl_wdata = irq_ctrl_wdata_q;

    // The fetch side must not present a new word while this is high.
    assign o_flush = flush_q;
    assign o_busy = busy_q;
endmodule

// >>> test/sore_exec_props.sv
// Checker for the execute block, bound to sore_exec.
// Assumes it sees only the block's ports.
module sore_exec_props (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_instr_valid,
    input wire [13:0] i_instr,
    input wire [7:0] i_accum,
    input wire [12:0] i_pc,
    input wire [12:0] i_stack_top_entry,
    input wire [7:0] i_interrupt_control_reg,
    input wire o_file_we,
    input wire [6:0] o_file_addr,
    input wire [7:0] o_file_wdata,
    input wire [7:0] o_option_reg,
    input wire o_stack_pop,
    input wire o_pc_load,
    input wire [12:0] o_pc_next,
    input wire o_irq_ctrl_we,
    input wire [7:0] o_irq_ctrl_wdata,
    input wire o_flush,
    input wire o_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    wire acc = i_instr_valid && !o_busy;
    wire st = acc && (i_instr & 14'h3F80) == 14'h0080;
    wire ir = acc && i_instr == 14'h0009;
    wire nop = acc && (i_instr & 14'h3F9F) == 14'h0000;
    sequence s_quiet; !o_busy && !o_stack_pop && !o_pc_load; endsequence
    a_store_write: assert property (st |=> o_file_we && o_file_addr == $past(i_instr[6:0])
        && o_file_wdata == $past(i_accum)) else $error("bad store");
    a_option_load: assert property (acc && i_instr == 14'h0062 |=> o_option_reg == $past(i_accum))
        else $error("bad option");
    a_option_alias: assert property (st && i_instr[6:0] == 7'h01 |=> o_option_reg == $past(i_accum))
        else $error("bad alias");
    a_iret_pop: assert property (ir |=> o_stack_pop && o_pc_next == $past(i_stack_top_entry))
        else $error("bad pop");
    a_iret_gie: assert property (ir |=> o_irq_ctrl_we
        && o_irq_ctrl_wdata == ($past(i_interrupt_control_reg) | 8'h80)) else $error("bad enable");
    a_iret_two: assert property (ir |=> o_busy && o_flush ##1 s_quiet)
        else $error("bad return");
    a_nop_quiet: assert property (nop |=> !o_file_we && !o_irq_ctrl_we && !o_stack_pop
        && $stable(o_option_reg) && o_pc_next == $past(i_pc) + 13'h1) else $error("bad nop");
endmodule
bind sore_exec sore_exec_props i_props (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_accum(i_accum), .i_pc(i_pc), .i_stack_top_entry(i_stack_top_entry),
    .i_interrupt_control_reg(i_interrupt_control_reg), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
    .o_file_wdata(o_file_wdata), .o_option_reg(o_option_reg), .o_stack_pop(o_stack_pop),
    .o_pc_load(o_pc_load), .o_pc_next(o_pc_next), .o_irq_ctrl_we(o_irq_ctrl_we),
    .o_irq_ctrl_wdata(o_irq_ctrl_wdata), .o_flush(o_flush), .o_busy(o_busy)
);

// >>> test/sore_tb.sv
// Random bench comparing sore_exec with a model.
// Assumes the design and checker are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_ref_clk = 0, i_arst_n = 0, i_instr_valid = 0, a, st, ir, eb = 0;
    logic [13:0] i_instr = 0;
    logic [7:0] i_accum = 0, i_interrupt_control_reg = 0, ew = 0, eo = 8'hFF;
    logic [12:0] i_pc = 0, i_stack_top_entry = 0;
    logic [6:0] ea = 0;
    wire o_file_we, o_stack_pop, o_pc_load, o_irq_ctrl_we, o_flush, o_busy;
    wire [6:0] o_file_addr;
    wire [7:0] o_file_wdata, o_option_reg, o_irq_ctrl_wdata;
    wire [12:0] o_pc_next;
    int fails = 0, comparisons = 0;
    sore_exec i_sore_exec (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_accum(i_accum), .i_pc(i_pc), .i_stack_top_entry(i_stack_top_entry),
        .i_interrupt_control_reg(i_interrupt_control_reg), .o_file_we(o_file_we), .o_file_addr(o_file_addr),
        .o_file_wdata(o_file_wdata), .o_option_reg(o_option_reg), .o_stack_pop(o_stack_pop),
        .o_pc_load(o_pc_load), .o_pc_next(o_pc_next), .o_irq_ctrl_we(o_irq_ctrl_we),
        .o_irq_ctrl_wdata(o_irq_ctrl_wdata), .o_flush(o_flush), .o_busy(o_busy)
    );
    initial forever #5 i_ref_clk = ~i_ref_clk;
    task chk(input string n, input logic [15:0] s, e);
        comparisons++;
        if (s !== e) fails++;
        if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
    endtask
    task conclude;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #40us fails++;
        conclude;
    end
    initial begin
        void'($urandom(78784));
        repeat (6) @(posedge i_ref_clk);
        @(negedge i_ref_clk) i_arst_n = 1;
        repeat (3000) begin
            @(negedge i_ref_clk);
            a = i_instr_valid && !eb;
            st = a && (i_instr & 14'h3F80) == 14'h0080;
            ir = a && i_instr == 14'h0009;
            eb = ir;
            if (st) {ea, ew} = {i_instr[6:0], i_accum};
            if (st && ea == 7'h01 || a && i_instr == 14'h0062) eo = i_accum;
            chk("file", {o_file_we, o_file_addr, o_file_wdata}, {st, ea, ew});
            chk("opt", o_option_reg, eo);
            chk("ret", {o_stack_pop, o_pc_load, o_irq_ctrl_we, o_flush, o_busy}, {5{ir}});
            if (a) chk("pc", o_pc_next, ir ? i_stack_top_entry : 13'(i_pc + 13'h1));
            if (ir) chk("ctl", o_irq_ctrl_wdata, i_interrupt_control_reg | 8'h80);
            i_instr_valid = $urandom % 8 != 0;
            case ($urandom % 5)
                0: i_instr = 14'h0080 | ($urandom % 2 ? 14'h0001 : 14'($urandom % 128));
                1: i_instr = 14'h0062;
                2: i_instr = 14'(32 * ($urandom % 4));
                3: i_instr = 14'h0009;
                default: i_instr = 14'($urandom);
            endcase
            {i_accum, i_interrupt_control_reg, i_pc} = 29'($urandom);
            i_stack_top_entry = 13'($urandom);
        end
        conclude;
    end
endmodule
